// *** atc_pkg.sv ***
// atc_pkg: register map, control bit layout, timing and carrier types of the drive port
package atc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_HIGH_BYTE = 8'hDB;
  localparam logic [7:0] ADDR_LOW_BYTE = 8'hDC;
  localparam logic [7:0] ADDR_CTRL = 8'hDD;
  localparam logic [7:0] ADDR_UDMA_TIM = 8'hDE;
  localparam logic [7:0] ADDR_CNT0 = 8'hE1;
  localparam logic [7:0] ADDR_CNT1 = 8'hE2;
  localparam logic [7:0] ADDR_CNT2 = 8'hE3;
  localparam logic [7:0] ADDR_CNT3 = 8'hE4;
  // drive_port_control bit positions
  localparam int CTL_OUT_EN = 7;
  localparam int CTL_PIO_DONE = 6;
  localparam int CTL_CANCEL = 5;
  localparam int CTL_ERR = 4;
  localparam int CTL_ALT = 3;
  localparam int CTL_HANDS = 2;
  localparam int CTL_RSVD = 1;
  localparam int CTL_UDMA = 0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [31:0] CNT_ZERO = 32'h0000_0000;
  localparam logic [31:0] CNT_ONE = 32'h0000_0001;
  localparam logic [31:0] CNT_WORD = 32'h0000_0002;
  localparam logic [2:0] TIM_MODE4 = 3'h4;
  localparam logic [2:0] ALT_STATUS_SEL = 3'h6;
  // timing: ns figures, cycles derived from the 250 MHz clock, least times round up
  localparam int CLK_MHZ = 250;
  localparam int PIO_STROBE_NS = 120;
  localparam int PIO_RECOVER_NS = 70;
  localparam int MWDMA_CT_NS = 120;
  localparam int UDMA0_CT_NS = 267;
  localparam int UDMA1_CT_NS = 167;
  localparam int UDMA2_CT_NS = 133;
  localparam int UDMA3_CT_NS = 100;
  localparam int UDMA4_CT_NS = 66;
  localparam logic [7:0] PIO_STROBE_CYC = 8'((PIO_STROBE_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] PIO_RECOVER_CYC = 8'((PIO_RECOVER_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] MWDMA_CYC = 8'((MWDMA_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] UDMA0_CYC = 8'((UDMA0_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] UDMA1_CYC = 8'((UDMA1_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] UDMA2_CYC = 8'((UDMA2_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] UDMA3_CYC = 8'((UDMA3_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] UDMA4_CYC = 8'((UDMA4_CT_NS * CLK_MHZ + 999) / 1000);
  localparam logic [7:0] TIMER_ONE = 8'h01;
  localparam logic [7:0] TIMER_ZERO = 8'h00;

  // engine states, gray along idle -> pio strobe -> pio recover; recover -> idle changes both bits
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_PIO_STROBE = 2'b01,
    ST_PIO_RECOVER = 2'b11,
    ST_DMA_STROBE = 2'b10
  } atc_state_t;

  // drive-facing output pins
  typedef struct packed {
    logic [2:0] driveRegisterSelect;
    logic driveReadStrobeN;
    logic driveWriteStrobeN;
    logic driveSelect0N;
    logic driveSelect1N;
    logic driveDmaAck;
    logic [15:0] driveDataBus;
  } atc_drive_out_t;

  // output enables: control pins, data bus
  typedef struct packed {
    logic ctrlOe;
    logic dataOe;
  } atc_drive_oe_t;

  // one PIO access request from the microcontroller side
  typedef struct packed {
    logic write;
    logic altBlock;
    logic [2:0] regSel;
    logic [7:0] lowData;
  } atc_pio_req_t;
endpackage

// *** atc_transfer_control.sv ***
// atc_transfer_control: drive port control, PIO return data and bulk byte counter
`timescale 1ns/10ps
module atc_transfer_control
  import atc_pkg::*;
#(
  parameter int BUF_BYTES = 512
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // PIO request from the microcontroller bridge
  input wire logic pioReq,
  input wire atc_pio_req_t pioCmd,
  output logic registerAccessDone,
  // bulk data path
  input wire logic xferToDrive,
  input wire logic [15:0] dmaWrData,
  input wire logic xferStop,
  output logic [15:0] dmaRdData,
  output logic dmaWordValid,
  output logic xferBusy,
  output logic bufferSelect,
  output logic bufferAlternateEnable,
  output logic handsFreeTransferEnable,
  output logic drive0UdmaEnable,
  // drive pins
  input wire logic driveDmaReq,
  input wire logic [15:0] driveDataIn,
  output atc_drive_out_t driveOut,
  output atc_drive_oe_t driveOe
);

  // elaboration check: the A/B fill counter wraps by compare, so the size must be a power of two
  if (BUF_BYTES < 2 || (BUF_BYTES & (BUF_BYTES - 1)) != 0) begin : g_bad_buf
    $error("BUF_BYTES must be a power of two of at least 2");
  end

  localparam int BW = $clog2(BUF_BYTES);

  atc_state_t state_r;
  logic [7:0] timer_r;
  logic [7:0] lowByte_r;
  logic [7:0] highByte_r;
  logic [31:0] count_r;
  logic [2:0] udmaTiming_r;
  logic outEn_r;
  logic pioDone_r;
  logic cancel_r;
  logic err_r;
  logic alt_r;
  logic hands_r;
  logic udma_r;
  logic active_r;
  logic bufSel_r;
  logic [BW:0] bufFill_r;
  logic [7:0] regRdata_r;
  atc_pio_req_t pio_r;
  logic [2:0] reqSync_r;
  logic [15:0] dataSync1_r;
  logic [15:0] dataSync2_r;
  logic [15:0] dataSync3_r;
  logic [15:0] dataSeen_r;
  logic [15:0] dmaRdData_r;
  logic dmaWordValid_r;
  atc_drive_out_t driveOut_r;
  atc_drive_oe_t driveOe_r;

  logic wrCtrl, wrCnt0, pioStart, pioFinish, wordDone, earlyEnd, dmaStart;
  logic [7:0] dmaCyc;
  logic [31:0] countDec;

  // decoded write strobes and engine events
  assign wrCtrl = regWr && regAddr == ADDR_CTRL;
  assign wrCnt0 = regWr && regAddr == ADDR_CNT0;
  assign pioStart = state_r == ST_IDLE && pioReq;
  assign dmaStart = state_r == ST_IDLE && !pioReq && active_r && reqSync_r[2] && reqSync_r[1];
  assign pioFinish = state_r == ST_PIO_RECOVER && timer_r == TIMER_ONE;
  assign wordDone = state_r == ST_DMA_STROBE && timer_r == TIMER_ONE && active_r;
  assign earlyEnd = active_r && (xferStop || (wrCtrl && regWdata[CTL_CANCEL]));
  assign countDec = (count_r >= CNT_WORD) ? count_r - CNT_WORD : CNT_ZERO;

  // strobe length per word; reserved timing codes fall back to the slowest mode
  always_comb begin
    dmaCyc = MWDMA_CYC;
    if (udma_r) begin
      case (udmaTiming_r)
        3'h0: dmaCyc = UDMA0_CYC;
        3'h1: dmaCyc = UDMA1_CYC;
        3'h2: dmaCyc = UDMA2_CYC;
        3'h3: dmaCyc = UDMA3_CYC;
        TIM_MODE4: dmaCyc = UDMA4_CYC;
        default: dmaCyc = UDMA0_CYC;
      endcase
    end
  end

  // pin synchronisers: only the second and third stages are ever compared
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reqSync_r <= 3'h0;
      dataSync1_r <= 16'h0000;
      dataSync2_r <= 16'h0000;
      dataSync3_r <= 16'h0000;
      dataSeen_r <= 16'h0000;
    end else begin
      reqSync_r <= {reqSync_r[1:0], driveDmaReq};
      dataSync1_r <= driveDataIn;
      dataSync2_r <= dataSync1_r;
      dataSync3_r <= dataSync2_r;
      if (dataSync2_r == dataSync3_r) begin
        dataSeen_r <= dataSync3_r;
      end
    end
  end

  // access engine: a PIO request wins over a pending DMA word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
      timer_r <= TIMER_ZERO;
      pio_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (pioStart) begin
            state_r <= ST_PIO_STROBE;
            timer_r <= PIO_STROBE_CYC;
            pio_r <= pioCmd;
          end else if (dmaStart) begin
            state_r <= ST_DMA_STROBE;
            timer_r <= dmaCyc;
          end
        end
        ST_PIO_STROBE: begin
          if (timer_r == TIMER_ONE) begin
            state_r <= ST_PIO_RECOVER;
            timer_r <= PIO_RECOVER_CYC;
          end else begin
            timer_r <= timer_r - TIMER_ONE;
          end
        end
        ST_PIO_RECOVER: begin
          if (timer_r == TIMER_ONE) begin
            state_r <= ST_IDLE;
          end else begin
            timer_r <= timer_r - TIMER_ONE;
          end
        end
        ST_DMA_STROBE: begin
          // an abort cuts the strobe short
          if (timer_r == TIMER_ONE || !active_r || earlyEnd) begin
            state_r <= ST_IDLE;
            timer_r <= TIMER_ZERO;
          end else begin
            timer_r <= timer_r - TIMER_ONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
          timer_r <= TIMER_ZERO;
        end
      endcase
    end
  end

  // pins registered from the engine state; everything floats while output enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      driveOut_r <= '{driveRegisterSelect: 3'h0, driveReadStrobeN: 1'b1,
                      driveWriteStrobeN: 1'b1, driveSelect0N: 1'b1, driveSelect1N: 1'b1,
                      driveDmaAck: 1'b0, driveDataBus: 16'h0000};
      driveOe_r <= '0;
    end else begin
      driveOut_r.driveRegisterSelect <= pio_r.regSel;
      driveOut_r.driveSelect0N <= !(state_r != ST_IDLE && state_r != ST_DMA_STROBE
                                    && !pio_r.altBlock);
      driveOut_r.driveSelect1N <= !(state_r != ST_IDLE && state_r != ST_DMA_STROBE
                                    && pio_r.altBlock);
      driveOut_r.driveReadStrobeN <= !((state_r == ST_PIO_STROBE && !pio_r.write)
                                       || (state_r == ST_DMA_STROBE && !xferToDrive));
      driveOut_r.driveWriteStrobeN <= !((state_r == ST_PIO_STROBE && pio_r.write)
                                        || (state_r == ST_DMA_STROBE && xferToDrive));
      driveOut_r.driveDmaAck <= state_r == ST_DMA_STROBE;
      // word writes carry the preloaded high byte
      driveOut_r.driveDataBus <= (state_r == ST_DMA_STROBE) ? dmaWrData
                                 : {highByte_r, pio_r.lowData};
      driveOe_r.ctrlOe <= outEn_r;
      driveOe_r.dataOe <= outEn_r && ((state_r == ST_DMA_STROBE && xferToDrive)
                          || (state_r != ST_IDLE && state_r != ST_DMA_STROBE && pio_r.write));
    end
  end

  // PIO return bytes land at the end of the read strobe, before the done flag
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lowByte_r <= BYTE_ZERO;
      highByte_r <= BYTE_ZERO;
    end else begin
      if (state_r == ST_PIO_STROBE && timer_r == TIMER_ONE && !pio_r.write) begin
        lowByte_r <= dataSeen_r[7:0];
        if (!pio_r.altBlock && pio_r.regSel == 3'h0) begin
          highByte_r <= dataSeen_r[15:8];
        end
      end else if (regWr && regAddr == ADDR_LOW_BYTE) begin
        lowByte_r <= regWdata;
      end else if (regWr && regAddr == ADDR_HIGH_BYTE) begin
        highByte_r <= regWdata;
      end
    end
  end

  // completion flag: the hardware set wins over a same-cycle write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pioDone_r <= 1'b0;
    end else if (pioFinish) begin
      pioDone_r <= 1'b1;
    end else if (pioStart || (wrCtrl && regWdata[CTL_PIO_DONE])) begin
      pioDone_r <= 1'b0;
    end
  end

  // plain control bits; a one written to hands-free forces toggling on as well
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      outEn_r <= 1'b0;
      alt_r <= 1'b0;
      hands_r <= 1'b0;
      udma_r <= 1'b0;
      udmaTiming_r <= 3'h0;
    end else begin
      if (wrCtrl) begin
        outEn_r <= regWdata[CTL_OUT_EN];
        alt_r <= regWdata[CTL_ALT] || regWdata[CTL_HANDS];
        hands_r <= regWdata[CTL_HANDS];
        udma_r <= regWdata[CTL_UDMA];
      end
      if (regWr && regAddr == ADDR_UDMA_TIM) begin
        udmaTiming_r <= regWdata[2:0];
      end
    end
  end

  // byte counter and transfer status; an error event wins over an init in the same cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_r <= CNT_ZERO;
      active_r <= 1'b0;
      cancel_r <= 1'b0;
      err_r <= 1'b0;
    end else begin
      if (wrCnt0) begin
        count_r[7:0] <= regWdata;
        active_r <= 1'b1;
        cancel_r <= 1'b0;
        err_r <= 1'b0;
      end else if (regWr && regAddr == ADDR_CNT1) begin
        count_r[15:8] <= regWdata;
      end else if (regWr && regAddr == ADDR_CNT2) begin
        count_r[23:16] <= regWdata;
      end else if (regWr && regAddr == ADDR_CNT3) begin
        count_r[31:24] <= regWdata;
      end else if (wordDone) begin
        count_r <= countDec;
        if (countDec == CNT_ZERO) begin
          active_r <= 1'b0;
        end
      end else if (active_r && count_r == CNT_ZERO) begin
        active_r <= 1'b0;
      end
      if (wrCtrl && regWdata[CTL_CANCEL]) begin
        cancel_r <= 1'b1;
      end
      if (earlyEnd) begin
        active_r <= 1'b0;
        err_r <= 1'b1;
      end
    end
  end

  // A/B buffer record: stepped only by moved bytes, so an error freezes it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufSel_r <= 1'b0;
      bufFill_r <= '0;
    end else if (wrCnt0) begin
      bufFill_r <= '0;
    end else if (wordDone && alt_r) begin
      if (bufFill_r + (BW + 1)'(2) >= (BW + 1)'(BUF_BYTES)) begin
        bufFill_r <= '0;
        bufSel_r <= !bufSel_r;
      end else begin
        bufFill_r <= bufFill_r + (BW + 1)'(2);
      end
    end
  end

  // bulk read words handed on as they finish
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      dmaRdData_r <= 16'h0000;
      dmaWordValid_r <= 1'b0;
    end else begin
      dmaWordValid_r <= wordDone;
      if (wordDone && !xferToDrive) begin
        dmaRdData_r <= dataSeen_r;
      end
    end
  end

  // read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata_r <= BYTE_ZERO;
    end else if (regRd) begin
      case (regAddr)
        ADDR_HIGH_BYTE: regRdata_r <= highByte_r;
        ADDR_LOW_BYTE: regRdata_r <= lowByte_r;
        ADDR_CTRL: regRdata_r <= {outEn_r, pioDone_r, cancel_r, err_r, alt_r, hands_r,
                                  1'b1, udma_r};
        ADDR_UDMA_TIM: regRdata_r <= {5'h00, udmaTiming_r};
        ADDR_CNT0: regRdata_r <= count_r[7:0];
        ADDR_CNT1: regRdata_r <= count_r[15:8];
        ADDR_CNT2: regRdata_r <= count_r[23:16];
        ADDR_CNT3: regRdata_r <= count_r[31:24];
        default: regRdata_r <= BYTE_ZERO;
      endcase
    end else begin
      regRdata_r <= BYTE_ZERO;
    end
  end

  assign regRdata = regRdata_r;
  assign registerAccessDone = pioDone_r;
  assign dmaRdData = dmaRdData_r;
  assign dmaWordValid = dmaWordValid_r;
  assign xferBusy = active_r;
  assign bufferSelect = bufSel_r;
  assign bufferAlternateEnable = alt_r;
  assign handsFreeTransferEnable = hands_r;
  assign drive0UdmaEnable = udma_r;
  assign driveOut = driveOut_r;
  assign driveOe = driveOe_r;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  property p_done_set; pioFinish |=> pioDone_r; endproperty
  a_done_set: assert property (p_done_set) else $error("done flag not set");
  property p_done_clr; pioStart |=> !pioDone_r; endproperty
  a_done_clr: assert property (p_done_clr) else $error("done flag not cleared");
  property p_cancel_err; earlyEnd |=> err_r && !active_r; endproperty
  a_cancel_err: assert property (p_cancel_err) else $error("abort lost");
  property p_init_clr; wrCnt0 && !earlyEnd |=> !err_r && !cancel_r && active_r; endproperty
  a_init_clr: assert property (p_init_clr) else $error("init failed");
  property p_rsvd; regRd && regAddr == ADDR_CTRL |=> regRdata_r[CTL_RSVD]; endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bit not one");
  property p_cnt_rd; regRd && regAddr == ADDR_CNT0 |=> regRdata_r == $past(count_r[7:0]);
  endproperty
  a_cnt_rd: assert property (p_cnt_rd) else $error("count readback wrong");
  property p_pins_off; !outEn_r |=> !driveOe_r.ctrlOe && !driveOe_r.dataOe; endproperty
  a_pins_off: assert property (p_pins_off) else $error("pins driven while off");
  property p_hands; wrCtrl && regWdata[CTL_HANDS] |=> alt_r; endproperty
  a_hands: assert property (p_hands) else $error("toggle not forced");
  property p_buf_hold; err_r && !active_r && !wrCnt0 |=> $stable(bufSel_r); endproperty
  a_buf_hold: assert property (p_buf_hold) else $error("buffer record moved");
  property p_dec; wordDone && !earlyEnd |=> count_r == $past(countDec); endproperty
  a_dec: assert property (p_dec) else $error("count not decremented");
  property p_pio_len; pioStart |=> state_r == ST_PIO_STROBE [*2]; endproperty
  a_pio_len: assert property (p_pio_len) else $error("strobe too short");

  c_pio: cover property (pioFinish);
  c_word: cover property (wordDone ##[1:200] wordDone);
  c_abort: cover property (active_r && earlyEnd);
  c_done: cover property (wordDone && countDec == CNT_ZERO);

endmodule // atc_transfer_control

// *** atc_drive_model.sv ***
// atc_drive_model: behavioural drive on the far side of the drive port
`timescale 1ns/10ps
module atc_drive_model
  import atc_pkg::*;
(
  // clock
  input wire logic clk,
  // drive pins from the block
  input wire atc_drive_out_t driveOut,
  input wire atc_drive_oe_t driveOe,
  // bench controls
  input wire logic reqEn,
  input wire logic [15:0] readWord,
  // drive pins toward the block
  output logic [15:0] driveDataIn,
  output logic driveDmaReq
);
  logic [15:0] lastData_r = 16'h0000;
  logic readActive;
  // the drive answers only a live read strobe qualified by a select or dack
  assign readActive = driveOe.ctrlOe && !driveOut.driveReadStrobeN &&
    (driveOut.driveDmaAck || !driveOut.driveSelect0N || !driveOut.driveSelect1N);
  // released bus shows the inverse of the last word driven, so a stale value never looks valid
  always @(posedge clk) begin
    if (readActive) begin
      lastData_r <= readWord;
    end
  end
  assign driveDataIn = readActive ? readWord : ~lastData_r;
  // request follows the bench; a drive holds it for as long as it has data
  assign driveDmaReq = reqEn;
endmodule // atc_drive_model

// *** atc_transfer_control_test.sv ***
// atc_transfer_control_test: directed register, PIO and bulk transfer tests
`timescale 1ns/10ps
module atc_transfer_control_test;
  import atc_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic pioReq = 1'b0;
  atc_pio_req_t pioCmd = '0;
  logic registerAccessDone, xferStop = 1'b0;
  logic [15:0] dmaRdData, driveDataIn;
  logic dmaWordValid, xferBusy, bufferSelect, altEn, handsEn, udmaEn, driveDmaReq;
  logic reqEn = 1'b0;
  logic [15:0] readWord = 16'h5AC3;
  atc_drive_out_t driveOut;
  atc_drive_oe_t driveOe;
  int miscompares = 0;
  int n_checks = 0;
  int cycles = 0;
  logic [7:0] rv;

  always #2 clk = ~clk;

  atc_transfer_control #(.BUF_BYTES(8)) dut_u (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .pioReq(pioReq),
    .pioCmd(pioCmd), .registerAccessDone(registerAccessDone), .xferToDrive(1'b0),
    .dmaWrData(16'h0000), .xferStop(xferStop), .dmaRdData(dmaRdData),
    .dmaWordValid(dmaWordValid), .xferBusy(xferBusy), .bufferSelect(bufferSelect),
    .bufferAlternateEnable(altEn), .handsFreeTransferEnable(handsEn),
    .drive0UdmaEnable(udmaEn), .driveDmaReq(driveDmaReq), .driveDataIn(driveDataIn),
    .driveOut(driveOut), .driveOe(driveOe));

  atc_drive_model drive_u (.clk(clk), .driveOut(driveOut), .driveOe(driveOe), .reqEn(reqEn),
    .readWord(readWord), .driveDataIn(driveDataIn), .driveDmaReq(driveDmaReq));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one write cycle; the next call lets an edge pass so the strobe is never reassigned
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1 d = regRdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk({24'h0, d}, {24'h0, exp});
  endtask

  // count bytes high first, byte 0 last because it starts the transfer
  task automatic load_count(input logic [31:0] n);
    wr(ADDR_CNT3, n[31:24]);
    wr(ADDR_CNT2, n[23:16]);
    wr(ADDR_CNT1, n[15:8]);
    wr(ADDR_CNT0, n[7:0]);
  endtask

  task automatic reset_values();
    rdchk(ADDR_CTRL, 8'h02);
    rdchk(ADDR_CNT0, 8'h00);
    rdchk(ADDR_CNT3, 8'h00);
    rdchk(ADDR_LOW_BYTE, 8'h00);
    chk({30'h0, driveOe}, 32'h0);
    rdchk(8'hE0, 8'h00);
    wr(ADDR_UDMA_TIM, 8'hFF);
    rdchk(ADDR_UDMA_TIM, 8'h07);
    $display("test reset_values done");
  endtask

  task automatic control_bits();
    wr(ADDR_CTRL, 8'h81);
    rdchk(ADDR_CTRL, 8'h83);
    chk({29'h0, driveOe, udmaEn}, 32'h5);
    wr(ADDR_CTRL, 8'h04);
    rdchk(ADDR_CTRL, 8'h0E);
    chk({30'h0, handsEn, altEn}, 32'h3);
    chk({30'h0, driveOe}, 32'h0);
    wr(ADDR_CTRL, 8'h08);
    rdchk(ADDR_CTRL, 8'h0A);
    wr(ADDR_CTRL, 8'h90);
    rdchk(ADDR_CTRL, 8'h82);
    $display("test control_bits done");
  endtask

  // one PIO access; a write also checks the word on the pins once the strobe is out
  task automatic pio_access(input logic w, input logic [2:0] sel, input logic [7:0] lo,
                            input logic [15:0] word);
    @(posedge clk);
    pioCmd <= '{write: w, altBlock: 1'b0, regSel: sel, lowData: lo};
    pioReq <= 1'b1;
    @(posedge clk);
    pioReq <= 1'b0;
    #1 chk({31'h0, registerAccessDone}, 32'h0);
    @(posedge clk);
    #1;
    if (w) begin
      chk({14'h0, driveOe.dataOe, driveOut.driveWriteStrobeN, driveOut.driveDataBus},
          {16'h0002, word});
    end
    for (int i = 0; i < 100 && registerAccessDone !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({31'h0, registerAccessDone}, 32'h1);
  endtask

  // the flag is left set between accesses so the start-of-access clear is really seen
  task automatic pio_reads();
    pio_access(1'b0, 3'h1, 8'h00, 16'h0000);
    rdchk(ADDR_LOW_BYTE, 8'hC3);
    rdchk(ADDR_CTRL, 8'hC2);
    readWord <= 16'h1E7B;
    pio_access(1'b0, 3'h0, 8'h00, 16'h0000);
    rdchk(ADDR_LOW_BYTE, 8'h7B);
    rdchk(ADDR_HIGH_BYTE, 8'h1E);
    wr(ADDR_HIGH_BYTE, 8'hA5);
    pio_access(1'b1, 3'h0, 8'h5A, 16'hA55A);
    rdchk(ADDR_LOW_BYTE, 8'h7B);
    wr(ADDR_CTRL, 8'hC0);
    rdchk(ADDR_CTRL, 8'h82);
    $display("test pio_reads done");
  endtask

  // nine bytes move as five mode 4 words: 9, 7, 5, 3, 1, 0; the fourth word flips the buffer
  task automatic bulk_read();
    int gap;
    readWord <= 16'hB00C;
    wr(ADDR_UDMA_TIM, 8'h04);
    wr(ADDR_CTRL, 8'h89);
    load_count(32'h0000_0009);
    rdchk(ADDR_CTRL, 8'h8B);
    reqEn <= 1'b1;
    for (int i = 0; i < 300 && dmaWordValid !== 1'b1; i++) begin
      @(posedge clk);
      #1;
    end
    chk({16'h0, dmaRdData}, 32'hB00C);
    for (gap = 1; gap < 300; gap++) begin
      @(posedge clk);
      #1;
      if (dmaWordValid === 1'b1) break;
    end
    chk(gap, {24'h0, UDMA4_CYC} + 32'h1);
    rdchk(ADDR_CNT0, 8'h05);
    for (int i = 0; i < 900 && xferBusy !== 1'b0; i++) begin
      @(posedge clk);
      #1;
    end
    reqEn <= 1'b0;
    rdchk(ADDR_CNT0, 8'h00);
    rdchk(ADDR_CTRL, 8'h8B);
    chk({31'h0, bufferSelect}, 32'h1);
    $display("test bulk_read done");
  endtask

  task automatic abort_and_stop();
    load_count(32'h0100_0064);
    #1 chk({31'h0, xferBusy}, 32'h1);
    rdchk(ADDR_CNT3, 8'h01);
    wr(ADDR_CTRL, 8'hA0);
    rdchk(ADDR_CTRL, 8'hB2);
    chk({30'h0, xferBusy, bufferSelect}, 32'h1);
    wr(ADDR_CNT0, 8'h64);
    rdchk(ADDR_CTRL, 8'h82);
    @(posedge clk);
    xferStop <= 1'b1;
    @(posedge clk);
    xferStop <= 1'b0;
    rdchk(ADDR_CTRL, 8'h92);
    $display("test abort_and_stop done");
  endtask

  task automatic final_report();
    $display("checks=%0d miscompares=%0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // hang guard well above the longest expected run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      final_report();
    end
  end

  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    reset_values();
    control_bits();
    wr(ADDR_CTRL, 8'h80);
    pio_reads();
    bulk_read();
    abort_and_stop();
    final_report();
  end
endmodule // atc_transfer_control_test
